// File: iac_pkg.sv
package iac_pkg;
   // ==========================================================
   // Source arrangement
   localparam int IAC_GROUPS = 4;
   localparam int IAC_CHANNELS = 8;
   localparam int IAC_ROT_MIN_VERSION = 2;
   // ==========================================================
   // Register map, byte addresses
   localparam logic [7:0] IAC_CTRL_OFS = 8'h00;
   localparam logic [7:0] IAC_STAT_OFS = 8'h04;
   localparam logic [7:0] IAC_PEND_OFS = 8'h08;
   localparam logic [31:0] IAC_CTRL_RESET = 32'h0000_0000;
   // ==========================================================
   // Control field positions
   localparam int IAC_CTRL_BUS_MODE = 0;
   localparam int IAC_CTRL_DAISY = 1;
   localparam int IAC_CTRL_PCFG_LSB = 2;
   localparam int IAC_CTRL_SADDR_LSB = 4;
   localparam int IAC_CTRL_ROT = 7;
   localparam int IAC_CTRL_VBASE_LSB = 8;
   localparam int IAC_CTRL_USED = 11;
   // ==========================================================
   // Status field positions
   localparam int IAC_STAT_IRQ = 0;
   localparam int IAC_STAT_ACCEPTED = 1;
   localparam int IAC_STAT_SECOND = 2;
   localparam int IAC_STAT_CHAIN = 3;
   localparam int IAC_STAT_VEC_LSB = 8;
   // ==========================================================
   // Bus responses
   localparam logic [1:0] IAC_RESP_OKAY = 2'b00;
   localparam logic [1:0] IAC_RESP_SLVERR = 2'b10;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      IAC_PP_LOW = 2'b00,
      IAC_PP_HIGH = 2'b01,
      IAC_OPEN_DRAIN = 2'b10
   } iac_pcfg_t;
   typedef enum logic [1:0] {
      IAC_IDLE = 2'b00,
      IAC_ACK1 = 2'b01,
      IAC_GAP = 2'b11,
      IAC_ACK2 = 2'b10
   } iac_ack_state_t;
endpackage

// File: iac_interrupt_ack_cascade.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module iac_interrupt_ack_cascade #(
   parameter int SILICON_VERSION = 2
) (
   input wire logic aclk, // Clock, 40 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic [31:0] irq_src, // Interrupt status bits, group-major.
   input wire logic irq_acknowledge_n, // Acknowledge strobe, active low.
   input wire logic data_strobe_m_n, // Data strobe, active low.
   input wire logic [2:0] enable_in, // Enable pins as seen on the board.
   output logic [7:0] vector_bus, // Vector onto data bus low byte.
   output logic vector_bus_oe_n, // Low while the vector is driven.
   output logic irq_out, // Request pin level.
   output logic irq_out_oe_n, // Low while the request pin is driven.
   output logic chain_enable_out, // Chain enable towards lower priority.
   output logic chain_enable_out_oe_n, // Low while the chain pin is driven.
   input wire logic [7:0] s_axi_awaddr, // AXI4-Lite write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [7:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data ready.
);
   import iac_pkg::*;

   // ==========================================================
   // State
   logic [31:0] ctrl_reg;
   logic [31:0] served_reg;
   logic irq_reg;
   logic ack_prev_n_reg;
   iac_ack_state_t ack_reg;
   logic [7:0] vec_reg;
   logic [4:0] src_idx_reg;
   logic [2:0] rot_reg [IAC_GROUPS];
   logic [7:0] aw_addr_reg;
   logic aw_full_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_full_reg;

   // ==========================================================
   // Control decode
   wire bus_two_cycle = ctrl_reg[IAC_CTRL_BUS_MODE];
   wire daisy = ctrl_reg[IAC_CTRL_DAISY];
   wire iac_pcfg_t pcfg = iac_pcfg_t'(ctrl_reg[IAC_CTRL_PCFG_LSB +: 2]);
   wire [2:0] slave_addr = ctrl_reg[IAC_CTRL_SADDR_LSB +: 3];
   wire rotate = ctrl_reg[IAC_CTRL_ROT] && (SILICON_VERSION >= IAC_ROT_MIN_VERSION);
   wire [2:0] vbase = ctrl_reg[IAC_CTRL_VBASE_LSB +: 3];
   // The third enable pin only matters for slave addressing.
   wire chain_in = enable_in[1];
   wire ack_low = !irq_acknowledge_n;
   wire ack_fall = ack_low && ack_prev_n_reg;

   // ==========================================================
   // Priority search
   // Served sources stay masked until their status bit drops, so the next vector names a fresh source.
   wire [31:0] pend = irq_src & ~served_reg;

   function automatic logic [2:0] pick_ch(input logic [7:0] bits, input logic [2:0] start);
      logic [2:0] idx;
      logic [2:0] res;
      logic found;
      res = start;
      found = 1'b0;
      for (int i = 0; i < IAC_CHANNELS; i++) begin
         idx = start + i[2:0];
         if (!found && bits[idx]) begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   logic [IAC_GROUPS-1:0] g_any;
   logic [2:0] g_ch [IAC_GROUPS];
   genvar g;
   generate
      for (g = 0; g < IAC_GROUPS; g++) begin : g_grp
         wire [7:0] gbits = pend[g*IAC_CHANNELS +: IAC_CHANNELS];
         assign g_any[g] = |gbits;
         assign g_ch[g] = pick_ch(gbits, rotate ? rot_reg[g] : 3'b000);
      end
   endgenerate

   // Group 0 ranks highest; fixed order between groups.
   logic [1:0] win_grp;
   always_comb begin
      win_grp = 2'b00;
      for (int i = IAC_GROUPS - 1; i >= 0; i--) begin
         if (g_any[i]) begin
            win_grp = i[1:0];
         end
      end
   end
   wire [2:0] win_ch = g_ch[win_grp];
   wire [7:0] win_vec = {vbase, win_grp, win_ch};
   wire any_pend = |pend;

   // ==========================================================
   // Acknowledge sequencing
   wire accept_ok = irq_reg && (daisy ? chain_in : (enable_in == slave_addr));
   iac_ack_state_t ack_next;
   always_comb begin
      ack_next = ack_reg;
      unique case (ack_reg)
         IAC_IDLE: begin
            if (ack_fall && accept_ok) begin
               ack_next = IAC_ACK1;
            end
         end
         IAC_ACK1: begin
            if (!ack_low) begin
               ack_next = bus_two_cycle ? IAC_GAP : IAC_IDLE;
            end
         end
         IAC_GAP: begin
            if (ack_low) begin
               ack_next = IAC_ACK2;
            end
         end
         IAC_ACK2: begin
            if (!ack_low) begin
               ack_next = IAC_IDLE;
            end
         end
      endcase
   end
   wire service_done = (ack_reg != IAC_IDLE) && (ack_next == IAC_IDLE);
   wire [31:0] done_mask = service_done ? (32'h0000_0001 << src_idx_reg) : 32'h0000_0000;
   wire [31:0] served_next = (served_reg & irq_src) | done_mask;
   wire any_left = |(irq_src & ~served_next);
   wire chain_block = daisy && !chain_in;
   // A raise needs an idle acknowledge line and no service in progress.
   wire may_raise = !ack_low && (ack_reg == IAC_IDLE) && !service_done;
   wire irq_next = chain_block ? 1'b0 :
                   service_done ? any_left :
                   irq_reg ? any_pend :
                   (may_raise && any_pend);
   wire drive_next = ack_low && (((ack_next == IAC_ACK1) && !bus_two_cycle && !data_strobe_m_n) ||
                                 (ack_next == IAC_ACK2));
   wire chain_next = chain_in && !irq_next;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         served_reg <= 32'h0000_0000;
         irq_reg <= 1'b0;
         ack_prev_n_reg <= 1'b1;
         ack_reg <= IAC_IDLE;
         vec_reg <= 8'h00;
         src_idx_reg <= 5'h00;
         vector_bus <= 8'h00;
         vector_bus_oe_n <= 1'b1;
         chain_enable_out <= 1'b1;
         chain_enable_out_oe_n <= 1'b1;
      end else if (ce) begin
         served_reg <= served_next;
         irq_reg <= irq_next;
         ack_prev_n_reg <= irq_acknowledge_n;
         ack_reg <= ack_next;
         if ((ack_reg == IAC_IDLE) && (ack_next == IAC_ACK1)) begin
            vec_reg <= win_vec;
            src_idx_reg <= {win_grp, win_ch};
         end
         vector_bus <= ((ack_reg == IAC_IDLE) && (ack_next == IAC_ACK1)) ? win_vec : vec_reg;
         vector_bus_oe_n <= !drive_next;
         chain_enable_out <= chain_next;
         chain_enable_out_oe_n <= !daisy;
      end
   end

   always_ff @(posedge aclk) begin
      for (int i = 0; i < IAC_GROUPS; i++) begin
         if (!aresetn) begin
            rot_reg[i] <= 3'b000;
         end else if (ce && service_done && rotate && (src_idx_reg[4:3] == i[1:0])) begin
            rot_reg[i] <= src_idx_reg[2:0] + 3'b001;
         end
      end
   end

   // ==========================================================
   // Request pin drive
   // Open drain only ever pulls low, so the level is fixed and the enable carries the request.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out <= 1'b1;
         irq_out_oe_n <= 1'b1;
      end else if (ce) begin
         irq_out <= (pcfg == IAC_PP_HIGH) ? irq_next : (pcfg == IAC_PP_LOW) ? !irq_next : 1'b0;
         irq_out_oe_n <= (pcfg == IAC_OPEN_DRAIN) ? !irq_next : 1'b0;
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
   wire wr_ctrl = wr_go && (aw_addr_reg == IAC_CTRL_OFS);
   wire wr_known = (aw_addr_reg == IAC_CTRL_OFS) || (aw_addr_reg == IAC_STAT_OFS) ||
                   (aw_addr_reg == IAC_PEND_OFS);
   wire [31:0] strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [31:0] ctrl_used = (32'h0000_0001 << IAC_CTRL_USED) - 32'h0000_0001;
   wire [31:0] ctrl_wr = ((ctrl_reg & ~strb_mask) | (w_data_reg & strb_mask)) & ctrl_used;
   wire [31:0] stat_word = {16'h0000, vec_reg, 4'h0, chain_enable_out, ack_reg == IAC_ACK2,
                            ack_reg != IAC_IDLE, irq_reg};
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire rd_ctrl = s_axi_araddr == IAC_CTRL_OFS;
   wire rd_stat = s_axi_araddr == IAC_STAT_OFS;
   wire rd_pend = s_axi_araddr == IAC_PEND_OFS;
   wire [31:0] rd_word = rd_ctrl ? ctrl_reg : rd_stat ? stat_word : rd_pend ? pend : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= IAC_CTRL_RESET;
         aw_addr_reg <= 8'h00;
         aw_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         w_full_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IAC_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= IAC_RESP_OKAY;
      end else if (ce) begin
         if (aw_take) begin
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            aw_full_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_ctrl) begin
            ctrl_reg <= ctrl_wr;
         end
         if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? IAC_RESP_OKAY : IAC_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl || rd_stat || rd_pend) ? IAC_RESP_OKAY : IAC_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // iac_interrupt_ack_cascade

// File: iac_host_model.sv
`timescale 1ns/10ps
module iac_host_model (
   input wire logic aclk, // Clock.
   input wire logic start, // Begins one acknowledge.
   input wire logic two_cycle, // Two strobes.
   input wire logic [3:0] hold, // Strobe low time, 1 up.
   input wire logic vector_bus_oe_n, // Vector driven.
   input wire logic [7:0] vector_bus, // Vector lines.
   output logic irq_acknowledge_n, // Ack strobe.
   output logic data_strobe_m_n, // Data strobe.
   output logic done, // End pulse.
   output logic seen, // Vector came.
   output logic [7:0] vec // Last vector.
);
   logic [1:0] ph = 2'd0;
   logic [3:0] cnt = 4'h0;
   initial {irq_acknowledge_n, data_strobe_m_n, done, seen, vec} = 12'hC00;
   // ==========================================================
   // Only the strobes move; there are no select or grant pins to misuse.
   always @(posedge aclk) begin
      done <= 1'b0;
      if (!vector_bus_oe_n) begin
         seen <= 1'b1;
         vec <= vector_bus;
      end
      if (ph == 2'd0) begin
         if (start) begin
            ph <= 2'd1;
            cnt <= hold;
            seen <= 1'b0;
            irq_acknowledge_n <= 1'b0;
            data_strobe_m_n <= two_cycle;
         end
      end else if (cnt > 4'h1) begin
         cnt <= cnt - 4'h1;
      end else if (ph == 2'd1 && two_cycle) begin
         ph <= 2'd2;
         cnt <= 4'h2;
         irq_acknowledge_n <= 1'b1;
      end else if (ph == 2'd2) begin
         ph <= 2'd3;
         cnt <= hold;
         irq_acknowledge_n <= 1'b0;
      end else begin
         ph <= 2'd0;
         {irq_acknowledge_n, data_strobe_m_n, done} <= 3'b111;
      end
   end
endmodule // iac_host_model

// File: iac_checker.sv
`timescale 1ns/10ps
module iac_checker (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset.
   input wire logic [31:0] irq_src, // Sources.
   input wire logic irq_acknowledge_n, // Ack.
   input wire logic data_strobe_m_n, // Strobe.
   input wire logic [2:0] enable_in, // Enables.
   input wire logic [7:0] vector_bus, // Vector.
   input wire logic vector_bus_oe_n, // Vector on.
   input wire logic irq_out, // Request.
   input wire logic irq_out_oe_n, // Request on.
   input wire logic chain_enable_out, // Chain out.
   input wire logic [7:0] s_axi_awaddr, // Address.
   input wire logic s_axi_awvalid, // Valid.
   input wire logic s_axi_awready, // Ready.
   input wire logic [31:0] s_axi_wdata, // Data.
   input wire logic s_axi_wvalid, // Valid.
   input wire logic s_axi_wready // Ready.
);
   import iac_pkg::*;
   logic [10:0] c_q;
   logic act;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Control shadow; full-word writes only, so byte strobes are not watched.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_q <= 11'h000;
      end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                   s_axi_awaddr == IAC_CTRL_OFS) begin
         c_q <= s_axi_wdata[10:0];
      end
   end
   assign act = !irq_out_oe_n && (c_q[3:2] == 2'b01 ? irq_out : !irq_out);
   // ==========================================================
   // Properties
   vec_in_ack_a: assert property (!vector_bus_oe_n |-> $past(!irq_acknowledge_n))
      else $error("vector outside ack");
   vec_with_ds_a: assert property (!c_q[0] && !vector_bus_oe_n |-> $past(!data_strobe_m_n))
      else $error("vector without strobe");
   vec_source_a: assert property ($fell(vector_bus_oe_n) |->
      vector_bus[7:5] == c_q[10:8] && irq_src[vector_bus[4:0]])
      else $error("vector names no source");
   no_raise_a: assert property (!irq_acknowledge_n && !act |=> !act)
      else $error("raise during ack");
   drop_after_a: assert property ($rose(irq_acknowledge_n) && !vector_bus_oe_n && $onehot(irq_src) |=> !act)
      else $error("request kept after ack");
   chain_low_a: assert property (c_q[1] && !enable_in[1] |=> !chain_enable_out && !act)
      else $error("chain input low ignored");
   chain_block_a: assert property (c_q[1] && act |-> !chain_enable_out)
      else $error("chain not blocked");
   chain_back_a: assert property (c_q[1] && $fell(act) && enable_in[1] && $past(enable_in[1]) |->
      chain_enable_out)
      else $error("chain not restored");
endmodule // iac_checker
bind iac_interrupt_ack_cascade iac_checker u_iac_checker (.aclk, .aresetn, .irq_src, .irq_acknowledge_n,
   .data_strobe_m_n, .enable_in, .vector_bus, .vector_bus_oe_n, .irq_out, .irq_out_oe_n, .chain_enable_out,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready);

// File: iac_interrupt_ack_cascade_tb_top.sv
`timescale 1ns/10ps
module iac_interrupt_ack_cascade_tb_top;
   import iac_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0, done, seen;
   logic [31:0] irq_src = 32'h0, src = 32'h0, ctrl = 32'h0, rd, s_axi_wdata = 32'h0, s_axi_rdata;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, vector_bus, vec;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic irq_acknowledge_n, data_strobe_m_n, vector_bus_oe_n, irq_out, irq_out_oe_n;
   logic chain_enable_out, chain_enable_out_oe_n;
   logic [2:0] ie = 3'b000, enable_in;
   logic [3:0] hold = 4'h1;
   logic [15:0] rnd = 16'd33286;
   int fails = 0, compares = 0;
   // The chain pin reads back its own level while the block drives it.
   assign enable_in = chain_enable_out_oe_n ? ie : {ie[2:1], chain_enable_out};
   always #12.5 aclk = ~aclk;
   iac_interrupt_ack_cascade u_iac_interrupt_ack_cascade (.aclk, .aresetn, .ce(1'b1), .irq_src, .irq_acknowledge_n,
      .data_strobe_m_n, .enable_in, .vector_bus, .vector_bus_oe_n, .irq_out, .irq_out_oe_n, .chain_enable_out,
      .chain_enable_out_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   iac_host_model u_iac_host_model (.aclk, .start, .two_cycle(ctrl[0]), .hold, .vector_bus_oe_n, .vector_bus,
      .irq_acknowledge_n, .data_strobe_m_n, .done, .seen, .vec);
   // ==========================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] exp_vec(input logic [31:0] s);
      for (int i = 0; i < 32; i++) if (s[i]) return {ctrl[10:8], i[4:0]};
      return 8'h00;
   endfunction
   function automatic logic act();
      return !irq_out_oe_n && (ctrl[3:2] == 2'b01 ? irq_out : !irq_out);
   endfunction
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t value %h not %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t flag %b not %b", $time, g, e);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
      while (s_axi_bvalid !== 1'b1) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      while (s_axi_rvalid !== 1'b1) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      {rd, rsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   task automatic set_ctrl(input logic [31:0] d);
      ctrl = d;
      axi_wr(IAC_CTRL_OFS, d);
   endtask
   task automatic wait_for(input logic v, input logic on_ack);
      for (int n = 0; n < 40 && (on_ack ? irq_acknowledge_n : act()) !== v; n++) @(posedge aclk);
   endtask
   task automatic raise(input logic [4:0] b);
      // A source dropped just before must be seen low for one edge, or it stays masked as served.
      @(posedge aclk);
      src[b] = 1'b1;
      irq_src <= src;
      wait_for(1'b1, 1'b0);
      chk_bit(act(), 1'b1);
   endtask
   // One acknowledge; the served source is dropped only after it ends.
   task automatic serve(input logic [7:0] e, input logic acc);
      @(posedge aclk);
      rnd = lfsr(rnd);
      {start, hold} <= {1'b1, 2'b00, rnd[1:0] + 2'b01};
      @(posedge aclk);
      start <= 1'b0;
      wait_for(1'b0, 1'b1);
      if (ctrl[0]) begin
         wait_for(1'b1, 1'b1);
         chk_bit(act(), 1'b1);
      end
      for (int n = 0; n < 40 && done !== 1'b1; n++) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk_bit(seen, acc);
      if (acc) chk_val(32'(vec), 32'(e));
      src[e[4:0]] = src[e[4:0]] & !acc;
      irq_src <= src;
   endtask
   task automatic report_and_stop();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      #(25 * 20000);
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(IAC_CTRL_OFS);
      chk_val(rd, IAC_CTRL_RESET);
      chk_val(32'(rsp), 32'(IAC_RESP_OKAY));
      axi_wr(8'h0C, 32'hFFFF_FFFF);
      chk_val(32'(rsp), 32'(IAC_RESP_SLVERR));
      for (int p = 0; p < 3; p++) begin
         set_ctrl(32'(p) << 2);
         repeat (3) @(posedge aclk);
         chk_bit(irq_out_oe_n, p == 2);
         raise(5'd9);
         chk_bit(irq_out, p == 1);
         src = 32'h0;
         irq_src <= src;
         wait_for(1'b0, 1'b0);
         chk_bit(act(), 1'b0);
      end
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         set_ctrl({21'h0, rnd[10:8], 8'h00});
         raise({1'b0, rnd[0], rnd[4:2]});
         raise({1'b1, rnd[1], rnd[7:5]});
         serve(exp_vec(src), 1'b1);
         serve(exp_vec(src), 1'b1);
         chk_bit(act(), 1'b0);
      end
      set_ctrl(32'h0000_0050);
      ie <= 3'b011;
      raise(5'd20);
      serve(exp_vec(src), 1'b0);
      ie <= 3'b101;
      serve(exp_vec(src), 1'b1);
      ie <= 3'b000;
      set_ctrl(32'h0000_0001);
      raise(5'd3);
      serve(exp_vec(src), 1'b1);
      chk_bit(act(), 1'b0);
      set_ctrl(32'h0000_0080);
      raise(5'd0);
      raise(5'd1);
      serve(8'h00, 1'b1);
      raise(5'd0);
      serve(8'h01, 1'b1);
      serve(8'h00, 1'b1);
      ie <= 3'b110;
      set_ctrl(32'h0000_0002);
      @(posedge aclk);
      chk_bit(chain_enable_out_oe_n, 1'b0);
      raise(5'd12);
      chk_bit(chain_enable_out, 1'b0);
      ie <= 3'b000;
      repeat (2) @(posedge aclk);
      chk_bit(act() | chain_enable_out, 1'b0);
      ie <= 3'b010;
      raise(5'd12);
      serve(exp_vec(src), 1'b1);
      chk_bit(chain_enable_out & !act(), 1'b1);
      report_and_stop();
   end
endmodule // iac_interrupt_ack_cascade_tb_top
